// [design/threshold_relay_controller.sv]
// Threshold relay controller: peak detection, hysteresis, dwell delays, relay and LED
// Notes on behaviour
// - After reset show identification and version, then measure and control continuously.
// - Out-of-range result shows over or under marker instead of value.
// - Configuration changes never stall measurement or threshold evaluation.
// - Peak recognised only after rise then fall of at least peak amplitude.
// - Peak shown for display time; newer peak replaces it, restarts timer.
// - When display time expires without new peak, show current value again.
// - Zero time holds until escape in hold style, no holding in real style.
// - Rightmost decimal point flashes while a peak is shown.
// - Relay decision uses current value or peak value by selection.
// - LED mirrors relay; without relay LED alone shows exceedance.
// - Mode selects unused relay, one-threshold or two-threshold control.
// - With in-range input in one- or two-threshold mode, relay changes only after border crossing held beyond applicable delay.
// - Both delays zero means immediate change on border crossing.
// - Positive delays: switch on/off only after dwell beyond border.
// - Return across border before delay elapses keeps present relay state.
// - One threshold: setting picks relay state in zone A, opposite in B.
// - Out-of-range input forces relay on, off, or unchanged per alarm setting.
// - Two thresholds share hysteresis, mode, delays, unit and alarm setting.
// - Two thresholds: relay on inside (A) or outside (B) per setting.
// - Thresholds in either order; lower is start, higher is end.
// - Thresholds range -999 to 9999, midpoint of hysteresis band.
`timescale 1ns/100ps
`include "threshold_relay_params.svh"
module threshold_relay_controller (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_result_valid,
	input wire logic signed [15:0] i_result,
	input wire logic i_over_range,
	input wire logic i_under_range,
	input wire logic i_escape_key,
	input wire logic i_relay_fitted,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	output logic o_relay,
	output logic o_led,
	output threshold_relay_pkg::show_t o_show,
	output logic signed [15:0] o_display_value,
	output logic o_peak_shown,
	output logic o_decimal_point
);
	import threshold_relay_pkg::*;

	localparam logic [3:0] A_FIRST = 4'h0;
	localparam logic [3:0] A_SECOND = 4'h1;
	localparam logic [3:0] A_HYSTERESIS_SETTING = 4'h2;
	localparam logic [3:0] A_ON_DLY = 4'h3;
	localparam logic [3:0] A_OFF_DLY = 4'h4;
	localparam logic [3:0] A_CTRL = 4'h5;
	localparam logic [3:0] A_PEAK_AMP = 4'h6;
	localparam logic [3:0] A_PEAK_TIME = 4'h7;
	localparam logic [3:0] A_STATUS = 4'h8;
	localparam logic [3:0] A_PEAK_VAL = 4'h9;
	localparam logic [3:0] A_ID = 4'ha;
	localparam logic [3:0] A_VERSION = 4'hb;
	localparam int TICK_CYC = `TICK_CYC;
	localparam int ID_TICKS = `ID_SHOW_MS / `TICK_MS;
	localparam int FLASH_TICKS = `FLASH_MS / `TICK_MS;

	// Configuration registers
	logic signed [15:0] first_threshold_q, second_threshold_q, hysteresis_setting_q;
	logic signed [15:0] peak_amplitude_q;
	logic [15:0] switch_on_delay_q, switch_off_delay_q, peak_time_q;
	relay_mode_t relay_mode_q;
	logic mode_on_q;
	alarm_behaviour_t alarm_behaviour_q;
	time_unit_t time_unit_q;
	peak_display_style_t peak_display_style_q;
	logic use_peak_q;

	function automatic logic signed [15:0] clamp_thr(input logic [15:0] v);
		logic signed [15:0] s;
		s = signed'(v);
		if (s < `THR_MIN)
			return `THR_MIN;
		if (s > `THR_MAX)
			return `THR_MAX;
		return s;
	endfunction

	// Writes land in registers only; evaluation keeps running meanwhile
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			first_threshold_q <= `FIRST_THR_RST;
			second_threshold_q <= `SECOND_THR_RST;
			hysteresis_setting_q <= `HYSTERESIS_SETTING_RST;
			switch_on_delay_q <= 16'h0000;
			switch_off_delay_q <= 16'h0000;
			relay_mode_q <= RMODE_ONE;
			mode_on_q <= 1'b1;
			alarm_behaviour_q <= ALARM_OFF;
			time_unit_q <= UNIT_MS;
			peak_display_style_q <= STYLE_REAL;
			use_peak_q <= 1'b0;
			peak_amplitude_q <= `PEAK_AMP_RST;
			peak_time_q <= 16'h0000;
		end else if (i_wr) begin
			unique case (i_addr)
				A_FIRST: first_threshold_q <= clamp_thr(i_wdata);
				A_SECOND: second_threshold_q <= clamp_thr(i_wdata);
				A_HYSTERESIS_SETTING: hysteresis_setting_q <= signed'({1'b0, i_wdata[14:0]});
				A_ON_DLY: switch_on_delay_q <= i_wdata;
				A_OFF_DLY: switch_off_delay_q <= i_wdata;
				A_CTRL: begin
					relay_mode_q <= (i_wdata[1:0] == 2'h3) ? RMODE_UNUSED
						: relay_mode_t'(i_wdata[1:0]);
					mode_on_q <= i_wdata[2];
					alarm_behaviour_q <= (i_wdata[4:3] == 2'h3) ? ALARM_KEEP
						: alarm_behaviour_t'(i_wdata[4:3]);
					time_unit_q <= (i_wdata[6:5] == 2'h3) ? UNIT_S
						: time_unit_t'(i_wdata[6:5]);
					peak_display_style_q <= peak_display_style_t'(i_wdata[7]);
					use_peak_q <= i_wdata[8];
				end
				A_PEAK_AMP: peak_amplitude_q <= signed'({1'b0, i_wdata[14:0]});
				A_PEAK_TIME: peak_time_q <= i_wdata;
				default: ;
			endcase
		end
	end

	// Millisecond tick and unit ticks
	logic [15:0] tick_cnt_q;
	logic [6:0] ms100_cnt_q;
	logic [9:0] s_cnt_q;
	logic tick_ms, tick_100ms, tick_s, unit_tick;
	assign tick_ms = (tick_cnt_q == 16'(TICK_CYC - 1));
	assign tick_100ms = tick_ms && (ms100_cnt_q == 7'd99);
	assign tick_s = tick_ms && (s_cnt_q == 10'd999);
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tick_cnt_q <= 16'h0000;
			ms100_cnt_q <= 7'h00;
			s_cnt_q <= 10'h000;
		end else begin
			tick_cnt_q <= tick_ms ? 16'h0000 : tick_cnt_q + 16'h0001;
			if (tick_ms) begin
				ms100_cnt_q <= tick_100ms ? 7'h00 : ms100_cnt_q + 7'h01;
				s_cnt_q <= tick_s ? 10'h000 : s_cnt_q + 10'h001;
			end
		end
	end
	always_comb begin
		unique case (time_unit_q)
			UNIT_MS: unit_tick = tick_ms;
			UNIT_100MS: unit_tick = tick_100ms;
			default: unit_tick = tick_s;
		endcase
	end

	// Start-up identification phase
	logic startup_q;
	logic [15:0] id_cnt_q;
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			startup_q <= 1'b1;
			id_cnt_q <= 16'h0000;
		end else if (startup_q && tick_ms) begin
			id_cnt_q <= id_cnt_q + 16'h0001;
			if (id_cnt_q == 16'(ID_TICKS - 1))
				startup_q <= 1'b0;
		end
	end

	// Peak detection: track running max, peak when value falls by amplitude
	logic signed [15:0] run_max_q, peak_q, cur_q;
	logic cur_ok_q, peak_shown_q, peak_event, rose_q;
	logic [15:0] peak_timer_q;
	logic in_range;
	assign in_range = !i_over_range && !i_under_range;
	assign peak_event = i_result_valid && in_range && !startup_q && rose_q
		&& (32'(run_max_q) - 32'(i_result) >= 32'(peak_amplitude_q));
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_max_q <= 16'sh8000;
			cur_q <= 16'sh0000;
			cur_ok_q <= 1'b0;
			rose_q <= 1'b0;
		end else if (i_result_valid) begin
			cur_q <= i_result;
			cur_ok_q <= in_range;
			// Follows the valley until a rise, so a second fall alone is no peak
			if (!in_range || peak_event || i_result > run_max_q || !rose_q)
				run_max_q <= i_result;
			rose_q <= in_range && !peak_event && (rose_q || i_result > run_max_q);
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			peak_q <= 16'sh0000;
			peak_shown_q <= 1'b0;
			peak_timer_q <= 16'h0000;
		end else if (peak_event) begin
			peak_q <= run_max_q;
			peak_timer_q <= 16'h0000;
			peak_shown_q <= (peak_time_q != 16'h0000)
				|| (peak_display_style_q == STYLE_HOLD);
		end else if (peak_shown_q) begin
			if (peak_time_q == 16'h0000) begin
				if (peak_display_style_q == STYLE_REAL || i_escape_key)
					peak_shown_q <= 1'b0;
			end else if (tick_100ms) begin
				// Display time counts in tenths of a second
				if (peak_timer_q + 16'h0001 >= peak_time_q)
					peak_shown_q <= 1'b0;
				else
					peak_timer_q <= peak_timer_q + 16'h0001;
			end
		end
	end
	logic [15:0] flash_cnt_q;
	logic flash_q;
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flash_cnt_q <= 16'h0000;
			flash_q <= 1'b0;
		end else if (!peak_shown_q) begin
			flash_cnt_q <= 16'h0000;
			flash_q <= 1'b0;
		end else if (tick_ms) begin
			if (flash_cnt_q == 16'(FLASH_TICKS - 1)) begin
				flash_cnt_q <= 16'h0000;
				flash_q <= !flash_q;
			end else
				flash_cnt_q <= flash_cnt_q + 16'h0001;
		end
	end

	// Zone decision with hysteresis
	logic signed [15:0] ctrl_val, thr_lo, thr_hi;
	logic signed [17:0] lo_up, lo_dn, hi_up, hi_dn, v18;
	logic want_on, want_off, target, relay_q;
	assign ctrl_val = (use_peak_q && peak_shown_q) ? peak_q : cur_q;
	assign thr_lo = (first_threshold_q <= second_threshold_q)
		? first_threshold_q : second_threshold_q;
	assign thr_hi = (first_threshold_q <= second_threshold_q)
		? second_threshold_q : first_threshold_q;
	assign v18 = 18'(ctrl_val);
	assign lo_up = 18'(thr_lo) + 18'(hysteresis_setting_q);
	assign lo_dn = 18'(thr_lo) - 18'(hysteresis_setting_q);
	assign hi_up = 18'(thr_hi) + 18'(hysteresis_setting_q);
	assign hi_dn = 18'(thr_hi) - 18'(hysteresis_setting_q);
	always_comb begin
		want_on = 1'b0;
		want_off = 1'b0;
		// Zone A is below the single threshold; inside the pair for two thresholds
		if (relay_mode_q == RMODE_ONE) begin
			if (v18 < lo_dn) begin
				want_on = mode_on_q;
				want_off = !mode_on_q;
			end else if (v18 > lo_up) begin
				want_on = !mode_on_q;
				want_off = mode_on_q;
			end
		end else if (relay_mode_q == RMODE_TWO) begin
			if (v18 > lo_up && v18 < hi_dn) begin
				want_on = mode_on_q;
				want_off = !mode_on_q;
			end else if (v18 < lo_dn || v18 > hi_up) begin
				want_on = !mode_on_q;
				want_off = mode_on_q;
			end
		end
	end

	// Dwell counting toward the applicable delay
	logic [15:0] dwell_q;
	logic pending, pending_q, dwell_done;
	assign pending = relay_q ? want_off : want_on;
	assign target = !relay_q;
	assign dwell_done = relay_q ? (dwell_q >= switch_off_delay_q)
		: (dwell_q >= switch_on_delay_q);
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dwell_q <= 16'h0000;
			pending_q <= 1'b0;
		end else begin
			pending_q <= pending && cur_ok_q;
			if (!pending || !cur_ok_q || !pending_q)
				dwell_q <= 16'h0000;
			else if (unit_tick && dwell_q != 16'hffff)
				dwell_q <= dwell_q + 16'h0001;
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			relay_q <= 1'b0;
		else if (startup_q || relay_mode_q == RMODE_UNUSED)
			relay_q <= 1'b0;
		else if (!cur_ok_q) begin
			if (alarm_behaviour_q == ALARM_ON)
				relay_q <= 1'b1;
			else if (alarm_behaviour_q == ALARM_OFF)
				relay_q <= 1'b0;
		end else if (pending && dwell_done)
			relay_q <= target;
	end

	// Outputs
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_show <= SHOW_ID;
			o_display_value <= 16'sh0000;
			o_relay <= 1'b0;
			o_led <= 1'b0;
			o_peak_shown <= 1'b0;
			o_decimal_point <= 1'b0;
		end else begin
			o_relay <= relay_q && i_relay_fitted;
			o_led <= relay_q;
			o_peak_shown <= peak_shown_q && !startup_q;
			o_decimal_point <= peak_shown_q && flash_q && !startup_q;
			if (startup_q) begin
				o_show <= SHOW_ID;
				o_display_value <= (32'(id_cnt_q) * TICK_CYC + 32'(tick_cnt_q)
					< ID_TICKS * TICK_CYC / 2) ? `ID_CODE : `FW_VERSION;
			end else if (peak_shown_q) begin
				o_show <= SHOW_VALUE;
				o_display_value <= peak_q;
			end else if (i_over_range && i_result_valid) begin
				o_show <= SHOW_OVER;
			end else if (i_under_range && i_result_valid) begin
				o_show <= SHOW_UNDER;
			end else if (i_result_valid) begin
				o_show <= SHOW_VALUE;
				o_display_value <= i_result;
			end else if (o_show == SHOW_ID)
				o_show <= SHOW_VALUE;
		end
	end

	// Register read port
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_rdata <= 16'h0000;
		else if (i_rd) begin
			unique case (i_addr)
				A_FIRST: o_rdata <= first_threshold_q;
				A_SECOND: o_rdata <= second_threshold_q;
				A_HYSTERESIS_SETTING: o_rdata <= hysteresis_setting_q;
				A_ON_DLY: o_rdata <= switch_on_delay_q;
				A_OFF_DLY: o_rdata <= switch_off_delay_q;
				A_CTRL: o_rdata <= {7'h00, use_peak_q, peak_display_style_q, time_unit_q,
					alarm_behaviour_q, mode_on_q, relay_mode_q};
				A_PEAK_AMP: o_rdata <= peak_amplitude_q;
				A_PEAK_TIME: o_rdata <= peak_time_q;
				A_STATUS: o_rdata <= {11'h000, startup_q, !cur_ok_q, pending, peak_shown_q,
					relay_q};
				A_PEAK_VAL: o_rdata <= peak_q;
				A_ID: o_rdata <= `ID_CODE;
				A_VERSION: o_rdata <= `FW_VERSION;
				default: o_rdata <= 16'h0000;
			endcase
		end else
			o_rdata <= 16'h0000;
	end

	// Checks
	relay_unused_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		relay_mode_q == RMODE_UNUSED |=> !relay_q)
		else $error("relay active while unused");
	led_mirror_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		##1 o_led == $past(relay_q))
		else $error("led does not mirror relay");
	alarm_force_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!cur_ok_q && !startup_q && relay_mode_q != RMODE_UNUSED
		&& alarm_behaviour_q == ALARM_ON |=> relay_q)
		else $error("alarm did not force relay on");
	relay_change_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		cur_ok_q && !startup_q && relay_mode_q != RMODE_UNUSED && !pending |=> $stable(relay_q))
		else $error("relay changed without border crossing");
	dwell_restart_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!pending |=> dwell_q == 16'h0000)
		else $error("dwell not restarted");
	zero_delay_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		cur_ok_q && !startup_q && relay_mode_q != RMODE_UNUSED && pending
		&& switch_on_delay_q == 16'h0000 && switch_off_delay_q == 16'h0000 |=> $changed(relay_q))
		else $error("zero delay did not switch immediately");
	peak_restart_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		peak_event |=> peak_timer_q == 16'h0000 && peak_q == $past(run_max_q))
		else $error("new peak not taken");
	dp_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!peak_shown_q |=> !o_decimal_point)
		else $error("decimal point flashes without peak");
	real_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		peak_shown_q && !peak_event && peak_time_q == 16'h0000
		&& peak_display_style_q == STYLE_REAL |=> !peak_shown_q)
		else $error("real style with zero time held peak");
endmodule

// [design/threshold_relay_params.svh]
// Constants for the threshold relay controller
`ifndef THRESHOLD_RELAY_PARAMS_SVH
`define THRESHOLD_RELAY_PARAMS_SVH
`define VAL_W 16
`define THR_MIN 16'shfc19
`define THR_MAX 16'sh270f
`define CLK_HZ 40000000
`define TICK_MS 1
`define TICK_CYC ((`CLK_HZ / 1000) * `TICK_MS)
`define ID_SHOW_MS 1
`define FLASH_MS 250
`define DLY_W 16
`define PTIME_W 16
`define ID_CODE 16'h0a5a
`define FW_VERSION 16'h0001
`define FIRST_THR_RST 16'sh0064
`define SECOND_THR_RST 16'sh00c8
`define HYSTERESIS_SETTING_RST 16'sh0005
`define PEAK_AMP_RST 16'sh000a
`endif

// [design/threshold_relay_pkg.sv]
// Types for the threshold relay controller
package threshold_relay_pkg;
	typedef enum logic [1:0] {RMODE_UNUSED, RMODE_ONE, RMODE_TWO} relay_mode_t;
	typedef enum logic [1:0] {ALARM_ON, ALARM_OFF, ALARM_KEEP} alarm_behaviour_t;
	typedef enum logic [1:0] {UNIT_MS, UNIT_100MS, UNIT_S} time_unit_t;
	typedef enum logic {STYLE_REAL, STYLE_HOLD} peak_display_style_t;
	typedef enum logic [1:0] {SHOW_VALUE, SHOW_OVER, SHOW_UNDER, SHOW_ID} show_t;
endpackage

// [testbench/result_source.sv]
// Measurement result source model for the relay controller bench
`timescale 1ns/100ps
module result_source (
	input wire logic i_sys_clk,
	output logic o_result_valid,
	output logic signed [15:0] o_result,
	output logic o_over_range,
	output logic o_under_range
);
	initial begin
		o_result_valid = 1'b0;
		o_result = 16'sh0000;
		o_over_range = 1'b0;
		o_under_range = 1'b0;
	end

	// One-cycle strobe; lines show inverted data after it, so stale values are never trusted
	task automatic send(input logic signed [15:0] value, input logic over, input logic under);
		@(posedge i_sys_clk);
		o_result_valid <= 1'b1;
		o_result <= value;
		o_over_range <= over;
		o_under_range <= under;
		@(posedge i_sys_clk);
		o_result_valid <= 1'b0;
		o_result <= ~value;
		o_over_range <= ~over;
		o_under_range <= ~under;
	endtask
endmodule

// [testbench/tb_threshold_relay_controller.sv]
// Self-checking bench for the threshold relay controller
`timescale 1ns/100ps
`include "threshold_relay_params.svh"
module tb_threshold_relay_controller;
	import threshold_relay_pkg::*;
	// Start-up plus 50000 cycles (1.25 ms) for the dwell tests
	localparam int START_CYC = `ID_SHOW_MS * `TICK_CYC;
	localparam int LIMIT = START_CYC + 50000;
	logic i_sys_clk = 1'b0;
	logic i_reset_n;
	logic i_result_valid;
	logic signed [15:0] i_result;
	logic i_over_range;
	logic i_under_range;
	logic i_escape_key;
	logic i_relay_fitted;
	logic [3:0] i_addr;
	logic [15:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [15:0] o_rdata;
	logic o_relay;
	logic o_led;
	show_t o_show;
	logic signed [15:0] o_display_value;
	logic o_peak_shown;
	logic o_decimal_point;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;

	always #12.5 i_sys_clk = ~i_sys_clk;

	threshold_relay_controller dut (
		.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_result_valid(i_result_valid),
		.i_result(i_result), .i_over_range(i_over_range), .i_under_range(i_under_range),
		.i_escape_key(i_escape_key), .i_relay_fitted(i_relay_fitted), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_relay(o_relay),
		.o_led(o_led), .o_show(o_show), .o_display_value(o_display_value),
		.o_peak_shown(o_peak_shown), .o_decimal_point(o_decimal_point)
	);

	result_source src (
		.i_sys_clk(i_sys_clk), .o_result_valid(i_result_valid), .o_result(i_result),
		.o_over_range(i_over_range), .o_under_range(i_under_range)
	);

	task automatic final_report();
		if (bad_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			bad_count++;
			final_report();
		end
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		chk(name, o_rdata, exp);
	endtask

	// Result, then enough edges for the two-stage relay path and output register
	task automatic put(input logic signed [15:0] v, input logic ov, input logic un);
		src.send(v, ov, un);
		repeat (5) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic wait_led(input logic exp, input int max);
		for (int n = 0; n < max && o_led !== exp; n++) begin
			@(posedge i_sys_clk);
		end
		#1;
		chk("led_dwell", {15'h0000, o_led}, {15'h0000, exp});
	endtask

	function automatic logic [15:0] ctl(input logic pk, input logic hold, input logic [1:0] al,
		input logic on, input logic [1:0] md);
		return {7'h00, pk, hold, 2'h0, al, on, md};
	endfunction

	logic [15:0] rst_val [7] = '{16'h0064, 16'h00c8, 16'h0005, 16'h0000, 16'h0000, 16'h000d,
		16'h000a};
	logic signed [15:0] dual_in [4] = '{16'sh0096, 16'sh00fa, 16'sh0096, 16'sh0032};
	logic dual_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	logic signed [15:0] al_pre [3] = '{16'sh006e, 16'sh0032, 16'sh0032};
	logic al_ov [3] = '{1'b1, 1'b0, 1'b1};
	logic al_exp [3] = '{1'b1, 1'b0, 1'b1};
	show_t al_show [3] = '{SHOW_OVER, SHOW_UNDER, SHOW_OVER};

	initial begin
		int n;
		i_reset_n = 1'b0;
		i_escape_key = 1'b0;
		i_relay_fitted = 1'b1;
		i_addr = 4'h0;
		i_wdata = 16'h0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (20) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		@(posedge i_sys_clk);
		#1;
		chk("show_id", {14'h0000, o_show}, {14'h0000, SHOW_ID});
		chk("id_shown", o_display_value, `ID_CODE);
		rd(4'ha, `ID_CODE, "id_reg");
		rd(4'hb, `FW_VERSION, "version_reg");
		for (int r = 0; r < 7; r++) begin
			rd(r[3:0], rst_val[r], "reset_value");
		end
		rd(4'hc, 16'h0000, "unmapped");
		wr(4'h0, 16'h2710);
		rd(4'h0, 16'h270f, "thr_clamp_hi");
		wr(4'h0, 16'hfc18);
		rd(4'h0, 16'hfc19, "thr_clamp_lo");
		wr(4'h0, 16'h0064);
		put(16'sh0032, 1'b0, 1'b0);
		chk("startup_relay", {15'h0000, o_led}, 16'h0000);
		for (n = 0; n < LIMIT && o_show === SHOW_ID; n++) begin
			@(posedge i_sys_clk);
		end
		#1;
		chk("startup_len", {15'h0000, n >= START_CYC - 200 && n <= START_CYC}, 16'h0001);
		put(16'sh0032, 1'b0, 1'b0);
		chk("show_value", {14'h0000, o_show}, {14'h0000, SHOW_VALUE});
		chk("zone_a_on", {o_relay, o_led}, 16'h0003);
		put(16'sh0064, 1'b0, 1'b0);
		chk("band_keep", {15'h0000, o_led}, 16'h0001);
		put(16'sh006e, 1'b0, 1'b0);
		chk("zone_b_off", {o_relay, o_led}, 16'h0000);
		wr(4'h5, ctl(1'b0, 1'b0, 2'h1, 1'b0, 2'h1));
		put(16'sh006e, 1'b0, 1'b0);
		chk("mode_off_b", {15'h0000, o_led}, 16'h0001);
		i_relay_fitted <= 1'b0;
		put(16'sh006e, 1'b0, 1'b0);
		chk("no_relay", {o_relay, o_led}, 16'h0001);
		i_relay_fitted <= 1'b1;
		wr(4'h5, ctl(1'b0, 1'b0, 2'h1, 1'b0, 2'h0));
		put(16'sh006e, 1'b0, 1'b0);
		chk("unused", {15'h0000, o_led}, 16'h0000);
		wr(4'h0, 16'h00c8);
		wr(4'h1, 16'h0064);
		wr(4'h5, ctl(1'b0, 1'b0, 2'h1, 1'b1, 2'h2));
		for (int k = 0; k < 4; k++) begin
			put(dual_in[k], 1'b0, 1'b0);
			chk("dual", {15'h0000, o_led}, {15'h0000, dual_exp[k]});
		end
		wr(4'h0, 16'h0064);
		for (int k = 0; k < 3; k++) begin
			wr(4'h5, ctl(1'b0, 1'b0, k[1:0], 1'b1, 2'h1));
			put(al_pre[k], 1'b0, 1'b0);
			put(16'sh004d, al_ov[k], ~al_ov[k]);
			chk("alarm", {15'h0000, o_led}, {15'h0000, al_exp[k]});
			chk("range_mark", {14'h0000, o_show}, {14'h0000, al_show[k]});
		end
		wr(4'h5, ctl(1'b0, 1'b0, 2'h1, 1'b1, 2'h1));
		put(16'sh006e, 1'b0, 1'b0);
		wr(4'h3, 16'h0001);
		wr(4'h4, 16'h0001);
		// One ms dwell: the next tick after start-up is the only long wait
		put(16'sh0032, 1'b0, 1'b0);
		chk("on_early", {15'h0000, o_led}, 16'h0000);
		put(16'sh006e, 1'b0, 1'b0);
		put(16'sh0032, 1'b0, 1'b0);
		chk("dwell_restart", {15'h0000, o_led}, 16'h0000);
		wait_led(1'b1, 45000);
		put(16'sh006e, 1'b0, 1'b0);
		chk("off_early", {15'h0000, o_led}, 16'h0001);
		wr(4'h4, 16'h0000);
		wait_led(1'b0, 100);
		wr(4'h3, 16'h0000);
		wr(4'h4, 16'h0000);
		wr(4'h7, 16'h0000);
		put(16'sh0000, 1'b0, 1'b0);
		wr(4'h5, ctl(1'b1, 1'b1, 2'h1, 1'b1, 2'h1));
		put(16'sh0096, 1'b0, 1'b0);
		put(16'sh0091, 1'b0, 1'b0);
		chk("small_fall", {15'h0000, o_peak_shown}, 16'h0000);
		put(16'sh0082, 1'b0, 1'b0);
		chk("peak_seen", {15'h0000, o_peak_shown}, 16'h0001);
		rd(4'h9, 16'h0096, "peak_reg");
		put(16'sh0014, 1'b0, 1'b0);
		chk("peak_held", o_display_value, 16'h0096);
		chk("relay_peak", {15'h0000, o_led}, 16'h0000);
		i_escape_key <= 1'b1;
		@(posedge i_sys_clk);
		i_escape_key <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		put(16'sh0014, 1'b0, 1'b0);
		chk("escape", {15'h0000, o_peak_shown}, 16'h0000);
		chk("escape_val", o_display_value, 16'h0014);
		chk("dp_off", {15'h0000, o_decimal_point}, 16'h0000);
		chk("relay_cur", {15'h0000, o_led}, 16'h0001);
		wr(4'h5, ctl(1'b0, 1'b0, 2'h1, 1'b1, 2'h1));
		put(16'sh0000, 1'b0, 1'b0);
		put(16'sh003c, 1'b0, 1'b0);
		put(16'sh0028, 1'b0, 1'b0);
		chk("real_nohold", o_display_value, 16'h0028);
		final_report();
	end
endmodule
